// >>> rtl/ocd_core.sv
`timescale 1ns/1ps
// operation_code_byte fetch, operand gathering and instruction timing
// assumes program memory returns pm_data with pm_valid after pm_req
module ocd_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration: 1 = 12 clocks per machine cycle, 0 = 6
    input wire logic half_cycle_mode_sel,
    // active register bank and pointer register contents
    input wire logic [1:0] reg_bank,
    input wire logic [7:0] r0_value,
    input wire logic [7:0] r1_value,
    // program memory
    input wire logic [7:0] pm_data,
    input wire logic pm_valid,
    output logic pm_req,
    output logic [15:0] pm_addr,
    // decoded instruction
    output ocd_pkg::ocd_decode_type instr,
    output ocd_pkg::ocd_operand_type operand,
    output logic [7:0] reg_ram_addr,
    output logic [7:0] indirect_addr,
    output logic [7:0] clock_count,
    output logic instr_valid,
    output logic instr_done
);
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_WAIT_OP = 3'b001,
        ST_WAIT_B2 = 3'b010,
        ST_WAIT_B3 = 3'b011,
        ST_EXEC = 3'b100
    } ocd_state_type;

    logic rst_meta;
    logic rst_sync;
    ocd_state_type state;
    ocd_state_type next_state;
    ocd_pkg::ocd_decode_type tbl;
    ocd_pkg::ocd_decode_type next_instr;
    ocd_pkg::ocd_operand_type next_operand;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] next_byte2;
    logic [7:0] next_byte3;
    logic [15:0] pc;
    logic [15:0] next_pc;
    logic [15:0] next_pm_addr;
    logic next_pm_req;
    logic [7:0] next_reg_ram_addr;
    logic [7:0] next_indirect_addr;
    logic [7:0] next_clock_count;
    logic [7:0] clk_left;
    logic [7:0] next_clk_left;
    logic next_instr_valid;
    logic next_instr_done;

    // next-instruction address used by page and relative targets
    function automatic logic [15:0] page_target(input logic [15:0] nxt,
                                                input logic [7:0] op,
                                                input logic [7:0] lo8);
        return {nxt[15:11], op[7:5], lo8};
    endfunction

    function automatic ocd_pkg::ocd_space_type space_of(
        input logic [7:0] a);
        return (a < ocd_pkg::DIRECT_SPECIAL_BASE) ? ocd_pkg::SPACE_RAM
                                                  : ocd_pkg::SPACE_SPECIAL;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ocd_table u_table (
        .operation_code_byte(pm_data),
        .dec(tbl)
    );

    always_comb begin
        logic [7:0] mc_clk;
        logic [15:0] nxt_addr;
        logic [7:0] dir;
        mc_clk = half_cycle_mode_sel ? {4'h0, ocd_pkg::MC_CLK_12T}
                                     : {4'h0, ocd_pkg::MC_CLK_6T};
        nxt_addr = pc + {14'h0000, instr.length};
        dir = byte2;
        next_state = state;
        next_instr = instr;
        next_operand = operand;
        next_byte2 = byte2;
        next_byte3 = byte3;
        next_pc = pc;
        next_pm_addr = pm_addr;
        next_pm_req = 1'b0;
        next_reg_ram_addr = reg_ram_addr;
        next_indirect_addr = indirect_addr;
        next_clock_count = clock_count;
        next_clk_left = clk_left;
        next_instr_valid = instr_valid;
        next_instr_done = 1'b0;
        case (state)
            ST_FETCH: begin
                next_pm_req = 1'b1;
                next_pm_addr = pc;
                next_instr_valid = 1'b0;
                next_state = ST_WAIT_OP;
            end
            ST_WAIT_OP: begin
                if (pm_valid) begin
                    next_instr = tbl;
                    next_clock_count = 8'(tbl.mcycles * mc_clk);
                    next_reg_ram_addr = {3'b000, reg_bank, tbl.reg_num};
                    next_indirect_addr = tbl.ptr_sel ? r1_value
                                                     : r0_value;
                    if (tbl.length > 2'd1) begin
                        next_pm_req = 1'b1;
                        next_pm_addr = pc + 16'h0001;
                        next_state = ST_WAIT_B2;
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_WAIT_B2: begin
                if (pm_valid) begin
                    next_byte2 = pm_data;
                    if (instr.length == 2'd3) begin
                        next_pm_req = 1'b1;
                        next_pm_addr = pc + 16'h0002;
                        next_state = ST_WAIT_B3;
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_WAIT_B3: begin
                if (pm_valid) begin
                    next_byte3 = pm_data;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (!instr_valid) begin
                    next_instr_valid = 1'b1;
                    next_clk_left = clock_count - 8'h01;
                    next_operand = '0;
                    next_operand.imm16 = {byte2, byte3};
                    if (instr.opnd == ocd_pkg::OPND_DIRECT ||
                        instr.opnd == ocd_pkg::OPND_DIR_IMM) begin
                        next_operand.direct_addr = dir;
                        next_operand.direct_space = space_of(dir);
                    end
                    if (instr.opnd == ocd_pkg::OPND_DIR_IMM ||
                        instr.opnd == ocd_pkg::OPND_IMM) begin
                        next_operand.imm16 = (instr.length == 2'd3)
                            ? {byte2, byte3} : {8'h00, byte2};
                    end
                    // bit address: low half is RAM bit area, high half special
                    next_operand.bit_addr = byte2;
                    next_operand.bit_space = space_of(byte2);
                    if (instr.operation_code_byte == ocd_pkg::OP_LCALL ||
                        instr.operation_code_byte == ocd_pkg::OP_LJMP) begin
                        next_operand.target = {byte2, byte3};
                        next_operand.target_valid = 1'b1;
                    end else if (instr.operation_code_byte[3:0] == 4'h1) begin
                        next_operand.target = page_target(nxt_addr,
                            instr.operation_code_byte, byte2);
                        next_operand.target_valid = 1'b1;
                    end else if (instr.operation_code_byte ==
                                 ocd_pkg::OP_SJMP) begin
                        next_operand.target = nxt_addr +
                            {{8{byte2[7]}}, byte2};
                        next_operand.target_valid = 1'b1;
                    end
                end else if (clk_left != 8'h00) begin
                    next_clk_left = clk_left - 8'h01;
                end else begin
                    next_instr_done = 1'b1;
                    next_instr_valid = 1'b0;
                    next_pc = nxt_addr;
                    next_state = ST_FETCH;
                end
            end
            default: begin
                next_state = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= ST_FETCH;
            instr <= '0;
            operand <= '0;
            byte2 <= 8'h00;
            byte3 <= 8'h00;
            pc <= 16'h0000;
            pm_addr <= 16'h0000;
            pm_req <= 1'b0;
            reg_ram_addr <= 8'h00;
            indirect_addr <= 8'h00;
            clock_count <= 8'h00;
            clk_left <= 8'h00;
            instr_valid <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            state <= next_state;
            instr <= next_instr;
            operand <= next_operand;
            byte2 <= next_byte2;
            byte3 <= next_byte3;
            pc <= next_pc;
            pm_addr <= next_pm_addr;
            pm_req <= next_pm_req;
            reg_ram_addr <= next_reg_ram_addr;
            indirect_addr <= next_indirect_addr;
            clock_count <= next_clock_count;
            clk_left <= next_clk_left;
            instr_valid <= next_instr_valid;
            instr_done <= next_instr_done;
        end
    end
endmodule // ocd_core

// >>> common/ocd_pkg.sv
// package for the operation_code_byte decode and timing block
// assumes one 200 MHz clock; program memory answers fetches with a byte
// Notes on behaviour
// - every instruction starts with one operation_code_byte byte
// - operation_code_byte alone gives length one to three
// - register operand picks R0..R7 of bank
// - direct below 128 RAM, else special space
// - indirect address from R0 or R1
// - immediate taken from instruction bytes, 8 or 16
// - 16-bit target reaches whole program space
// - 11-bit target keeps page of next instruction
// - relative offset signed, added to next address
// - bit operand addresses RAM or special bit
// - add, addc, subb decode in pattern, short
// - data pointer increment takes two cycles: 24 clocks in 12T mode, 12 in 6T
// - multiply and divide take four cycles
// - logic ops; direct-immediate forms three bytes, long
// - moves into accumulator decode, short
// - duration in oscillator clocks, 6T halves
// - mode bit 1 gives 12 clocks, 0 gives 6
package ocd_pkg;
    localparam logic [3:0] MC_CLK_12T = 4'hc;
    localparam logic [3:0] MC_CLK_6T = 4'h6;
    localparam logic [7:0] DIRECT_SPECIAL_BASE = 8'h80;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_INC_DPTR16 = 8'ha3;
    localparam logic [7:0] OP_MUL = 8'ha4;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_LCALL = 8'h12;
    localparam logic [7:0] OP_LJMP = 8'h02;
    localparam logic [7:0] OP_MOV_DPTR16 = 8'h90;
    localparam logic [7:0] OP_SJMP = 8'h80;

    typedef enum logic [2:0] {
        OPND_NONE = 3'b000,
        OPND_REG = 3'b001,
        OPND_DIRECT = 3'b010,
        OPND_INDIRECT = 3'b011,
        OPND_IMM = 3'b100,
        OPND_DIR_IMM = 3'b101,
        OPND_ACC = 3'b110
    } ocd_opnd_type;

    typedef enum logic [1:0] {
        SPACE_NONE = 2'b00,
        SPACE_RAM = 2'b01,
        SPACE_SPECIAL = 2'b10
    } ocd_space_type;

    // what one decoded instruction looks like
    typedef struct packed {
        logic [7:0] operation_code_byte;
        logic [1:0] length;
        logic [2:0] mcycles;
        ocd_opnd_type opnd;
        logic [2:0] reg_num;
        logic ptr_sel;
        logic known;
    } ocd_decode_type;

    // operand-derived results
    typedef struct packed {
        logic [7:0] direct_addr;
        ocd_space_type direct_space;
        logic [15:0] imm16;
        logic [15:0] target;
        logic target_valid;
        logic [7:0] bit_addr;
        ocd_space_type bit_space;
    } ocd_operand_type;
endpackage

// >>> rtl/ocd_table.sv
`timescale 1ns/1ps
// combinational operation_code_byte table: length, machine cycles, operand form
// assumes the operation_code_byte byte is stable while it is looked at
module ocd_table (
    // operation_code_byte in
    input wire logic [7:0] operation_code_byte,
    // decode out
    output ocd_pkg::ocd_decode_type dec
);
    logic [3:0] hi;
    logic [3:0] lo;

    always_comb begin
        hi = operation_code_byte[7:4];
        lo = operation_code_byte[3:0];
        dec = '0;
        dec.operation_code_byte = operation_code_byte;
        dec.reg_num = operation_code_byte[2:0];
        dec.ptr_sel = operation_code_byte[0];
        dec.length = 2'd1;
        dec.mcycles = 3'd1;
        dec.opnd = ocd_pkg::OPND_NONE;
        dec.known = 1'b0;
        if (operation_code_byte == ocd_pkg::OP_NOP) begin
            dec.known = 1'b1;
        end else if (operation_code_byte == ocd_pkg::OP_INC_DPTR16) begin
            dec.known = 1'b1;
            dec.mcycles = 3'd2;
        end else if (operation_code_byte == ocd_pkg::OP_MUL ||
                     operation_code_byte == ocd_pkg::OP_DIV) begin
            dec.known = 1'b1;
            dec.mcycles = 3'd4;
        end else if (operation_code_byte == ocd_pkg::OP_LCALL ||
                     operation_code_byte == ocd_pkg::OP_LJMP) begin
            dec.known = 1'b1;
            dec.length = 2'd3;
            dec.mcycles = 3'd2;
            dec.opnd = ocd_pkg::OPND_IMM;
        end else if (operation_code_byte == ocd_pkg::OP_SJMP) begin
            dec.known = 1'b1;
            dec.length = 2'd2;
            dec.mcycles = 3'd2;
            dec.opnd = ocd_pkg::OPND_IMM;
        end else if (lo == 4'h1) begin
            dec.known = 1'b1;
            dec.length = 2'd2;
            dec.mcycles = 3'd2;
            dec.opnd = ocd_pkg::OPND_IMM;
        end else if (lo == 4'h3 && (hi <= 4'h3)) begin
            dec.known = 1'b1;
        end else if (lo == 4'h4 && (hi == 4'hc || hi == 4'hd ||
                     hi == 4'he || hi == 4'hf)) begin
            dec.known = 1'b1;
        end else if (hi <= 4'h1 || hi == 4'h2 || hi == 4'h3 ||
                     hi == 4'h4 || hi == 4'h5 || hi == 4'h6 ||
                     hi == 4'h9 || hi == 4'he) begin
            // arithmetic, inc/dec, logic and move-to-acc share one layout
            if (lo[3]) begin
                dec.known = 1'b1;
                dec.opnd = ocd_pkg::OPND_REG;
            end else if (lo[3:1] == 3'b011) begin
                dec.known = 1'b1;
                dec.opnd = ocd_pkg::OPND_INDIRECT;
            end else if (lo == 4'h5) begin
                dec.known = 1'b1;
                dec.length = 2'd2;
                dec.opnd = ocd_pkg::OPND_DIRECT;
            end else if (lo == 4'h4) begin
                dec.known = (hi >= 4'h2) && (hi != 4'he);
                if (hi <= 4'h1) begin
                    dec.known = 1'b1;
                    dec.opnd = ocd_pkg::OPND_ACC;
                end else begin
                    dec.length = 2'd2;
                    dec.opnd = ocd_pkg::OPND_IMM;
                end
            end else if (lo == 4'h2 && hi >= 4'h4 && hi <= 4'h6) begin
                dec.known = 1'b1;
                dec.length = 2'd2;
                dec.opnd = ocd_pkg::OPND_DIRECT;
            end else if (lo == 4'h3 && hi >= 4'h4 && hi <= 4'h6) begin
                dec.known = 1'b1;
                dec.length = 2'd3;
                dec.mcycles = 3'd2;
                dec.opnd = ocd_pkg::OPND_DIR_IMM;
            end
        end
        if (operation_code_byte == 8'h32 || operation_code_byte == 8'h22)
        begin
            dec.known = 1'b0;
        end
        if (!dec.known) begin
            dec.length = 2'd1;
            dec.mcycles = 3'd1;
            dec.opnd = ocd_pkg::OPND_NONE;
        end
    end
endmodule // ocd_table

// >>> sim/ocd_checker.sv
`timescale 1ns/1ps
// port-level checks for the decode and timing core
// assumes one clock domain and the raw asynchronous reset
module ocd_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and register state
    input wire logic half_cycle_mode_sel,
    input wire logic [1:0] reg_bank,
    input wire logic [7:0] r0_value,
    input wire logic [7:0] r1_value,
    // program memory
    input wire logic [7:0] pm_data,
    input wire logic pm_valid,
    input wire logic pm_req,
    input wire logic [15:0] pm_addr,
    // decoded instruction
    input ocd_pkg::ocd_decode_type instr,
    input ocd_pkg::ocd_operand_type operand,
    input wire logic [7:0] reg_ram_addr,
    input wire logic [7:0] indirect_addr,
    input wire logic [7:0] clock_count,
    input wire logic instr_valid,
    input wire logic instr_done
);
    logic [7:0] run_len;
    logic [7:0] next_run_len;
    always_comb begin
        next_run_len = instr_valid ? run_len + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_len <= 8'h00;
        end else begin
            run_len <= next_run_len;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    req_pulse_a: assert property (pm_req |=> !pm_req)
        else $error("fetch request longer than one cycle");
    addr_hold_a: assert property ($changed(pm_addr) |-> pm_req)
        else $error("fetch address moved without a request");
    valid_len_a: assert property (
        $fell(instr_valid) |-> run_len == clock_count)
        else $error("execution window differs from clock count");
    done_end_a: assert property ($fell(instr_valid) |-> instr_done)
        else $error("no done pulse at end of execution");
    done_cause_a: assert property (
        instr_done |-> $past(instr_valid) ##1 !instr_done)
        else $error("done pulse without execution or too long");
    mode_clock_a: assert property (instr_valid |-> clock_count ==
        {5'h00, instr.mcycles} * (half_cycle_mode_sel ? 8'h0c : 8'h06))
        else $error("clock count does not follow cycle mode");
    reg_field_a: assert property (instr_valid |->
        instr.reg_num == instr.operation_code_byte[2:0] &&
        instr.ptr_sel == instr.operation_code_byte[0])
        else $error("register or pointer field not from operation_code_byte");
    bank_addr_a: assert property (
        instr_valid && instr.opnd == ocd_pkg::OPND_REG
        |-> reg_ram_addr == {3'h0, reg_bank, instr.reg_num})
        else $error("register address outside active bank");
    space_split_a: assert property (
        instr_valid && instr.opnd == ocd_pkg::OPND_DIRECT
        |-> operand.direct_space == (operand.direct_addr[7] ?
        ocd_pkg::SPACE_SPECIAL : ocd_pkg::SPACE_RAM))
        else $error("direct address space split wrong");
    ind_ptr_a: assert property (
        instr_valid && instr.opnd == ocd_pkg::OPND_INDIRECT
        |-> indirect_addr == (instr.ptr_sel ? r1_value : r0_value))
        else $error("indirect address not from selected pointer");
    long_muldiv_a: assert property (
        instr_valid && (instr.operation_code_byte == 8'ha4 ||
        instr.operation_code_byte == 8'h84) |-> instr.mcycles == 3'h4)
        else $error("multiply or divide not four machine cycles");
    cover property (instr_done);
    cover property (instr_valid && instr.mcycles == 3'h4);
    cover property (instr_valid && operand.target_valid);
endmodule // ocd_checker

bind ocd_core ocd_checker chk (.clk(clk), .rst_n(rst_n),
    .half_cycle_mode_sel(half_cycle_mode_sel), .reg_bank(reg_bank),
    .r0_value(r0_value), .r1_value(r1_value), .pm_data(pm_data),
    .pm_valid(pm_valid), .pm_req(pm_req), .pm_addr(pm_addr), .instr(instr),
    .operand(operand), .reg_ram_addr(reg_ram_addr),
    .indirect_addr(indirect_addr), .clock_count(clock_count),
    .instr_valid(instr_valid), .instr_done(instr_done));

// >>> sim/ocd_pm_model.sv
`timescale 1ns/1ps
// program memory model answering one byte per fetch request
// assumes requests are one-cycle pulses sampled on the rising edge
module ocd_pm_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fetch request and answer delay
    input wire logic pm_req,
    input wire logic [15:0] pm_addr,
    input wire logic [1:0] lag,
    // answer
    output logic [7:0] pm_data,
    output logic pm_valid
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr;
    initial begin
        pm_valid = 1'b0;
        pm_data = 8'h5a;
    end
    always begin
        @(posedge clk);
        if (rst_n === 1'b1 && pm_req === 1'b1) begin
            addr = pm_addr;
            repeat (lag) @(posedge clk);
            @(negedge clk);
            pm_valid = 1'b1;
            pm_data = mem[addr];
            @(negedge clk);
            pm_valid = 1'b0;
            // released bus: show the inverse so stale data never matches
            pm_data = ~mem[addr];
        end
    end
endmodule // ocd_pm_model

// >>> sim/cpu_operation_code_byte_decode_timing_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the decode and timing core
// assumes the memory model holds the program laid out by the bench
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module cpu_operation_code_byte_decode_timing_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, mode = 1'b1;
    logic [1:0] bank = 2'h0, lag = 2'h0;
    logic [7:0] r0 = 8'h00, r1 = 8'h00, pm_data, reg_ram_addr, indirect_addr;
    logic [7:0] clock_count, op, b2, exp_clk;
    logic pm_valid, pm_req, instr_valid, instr_done, dir;
    logic [15:0] pm_addr, pc;
    ocd_pkg::ocd_decode_type instr;
    ocd_pkg::ocd_operand_type operand;
    ocd_pkg::ocd_space_type sp;
    int n_fail = 0, num_checks = 0, cycles = 0, i, n;
    // row: operation_code_byte, byte2, mode, length, machine cycles
    logic [27:0] rows [0:47] = '{
        28'h0000111, 28'h0000011, 28'h245a121, 28'h2585121, 28'h2600111,
        28'h2f00011, 28'h3700111, 28'h3c00011, 28'h357f021, 28'h9491121,
        28'h9600011, 28'h9b00111, 28'ha300112, 28'ha300012, 28'h0400111,
        28'h0f00011, 28'h1400111, 28'h1f00111, 28'h0580121, 28'h1512021,
        28'ha400114, 28'h8400014, 28'h5390132, 28'h4311032, 28'h63ff132,
        28'h5220121, 28'h4f00111, 28'hd400111, 28'he400011, 28'hf400111,
        28'h2300011, 28'h3300111, 28'h0300011, 28'h1300111, 28'hc400011,
        28'he800111, 28'hef00011, 28'he600111, 28'he700011, 28'he5c0121,
        28'h4433121, 28'h5444021, 28'h6455121, 28'h5700111, 28'h6600011,
        28'h6581021, 28'h4290021, 28'h62a1121};
    ocd_core uut (.clk(clk), .rst_n(rst_n), .half_cycle_mode_sel(mode),
        .reg_bank(bank), .r0_value(r0), .r1_value(r1), .pm_data(pm_data),
        .pm_valid(pm_valid), .pm_req(pm_req), .pm_addr(pm_addr),
        .instr(instr), .operand(operand), .reg_ram_addr(reg_ram_addr),
        .indirect_addr(indirect_addr), .clock_count(clock_count),
        .instr_valid(instr_valid), .instr_done(instr_done));
    ocd_pm_model pm (.clk(clk), .rst_n(rst_n), .pm_req(pm_req),
        .pm_addr(pm_addr), .lag(lag), .pm_data(pm_data), .pm_valid(pm_valid));
    always #2.5 clk = ~clk;
    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // the longest case walks some two thousand fetches
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic do_reset();
        int k;
        rst_n = 1'b0;
        for (k = 0; k < 65536; k++) pm.mem[k] = 8'h00;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic wait_op(input logic [7:0] code, input int limit);
        n = 0;
        while (!(instr_valid === 1'b1 && instr.operation_code_byte === code)
            && n < limit) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        do_reset();
        pc = 16'h0000;
        for (i = 0; i < 48; i++) begin
            pm.mem[pc] = rows[i][27:20];
            pm.mem[pc + 16'h1] = rows[i][19:12];
            pm.mem[pc + 16'h2] = ~rows[i][19:12];
            pc = pc + {14'h0, rows[i][5:4]};
        end
        for (i = 0; i < 48; i++) begin
            op = rows[i][27:20];
            b2 = rows[i][19:12];
            mode = rows[i][8];
            bank = i[1:0];
            lag = 2'(i % 3);
            r0 = 8'h10 + i[7:0];
            r1 = 8'hc0 + i[7:0];
            exp_clk = {4'h0, rows[i][3:0]} * (mode ? 8'h0c : 8'h06);
            wait_op(op, 300);
            `CHK(instr.operation_code_byte, op)
            `CHK(instr.known, 1'b1)
            `CHK(instr.length, rows[i][5:4])
            `CHK(clock_count, exp_clk)
            if (op[3]) `CHK(reg_ram_addr, {3'h0, bank, op[2:0]})
            if (op[3:1] == 3'h3) `CHK(indirect_addr, op[0] ? r1 : r0)
            dir = op[3:0] == 4'h5 || (op[3:1] == 3'h1 && op[7:4] inside
                {4'h4, 4'h5, 4'h6});
            if (dir) `CHK(operand.direct_addr, b2)
            sp = b2[7] ? ocd_pkg::SPACE_SPECIAL : ocd_pkg::SPACE_RAM;
            if (dir) `CHK(operand.direct_space, sp)
            if (dir) `CHK(operand.bit_addr, b2)
            if (dir) `CHK(operand.bit_space, sp)
            if (op inside {8'h24, 8'h34, 8'h94, 8'h44, 8'h54, 8'h64})
                `CHK(operand.imm16, {8'h00, b2})
            if (op inside {8'h43, 8'h53, 8'h63})
                `CHK(operand.imm16[7:0], ~b2)
            n = 0;
            while (instr_valid === 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            `CHK(n[7:0], exp_clk)
            `CHK(instr_done, 1'b1)
        end
        // reset in mid-instruction must clear the outputs at once
        wait_op(8'h00, 300);
        rst_n = 1'b0;
        @(negedge clk);
        `CHK({instr_valid, pm_req, pm_addr}, 18'h00000)
        do_reset();
        pm.mem[0] = 8'h02;
        pm.mem[1] = 8'hab;
        pm.mem[2] = 8'hcd;
        // an operation_code_byte outside the decoded set runs as one short cycle
        pm.mem[3] = 8'h22;
        wait_op(8'h02, 300);
        `CHK({operand.target_valid, operand.target}, 17'h1abcd)
        `CHK(instr.length, 2'h3)
        wait_op(8'h22, 300);
        `CHK({instr.known, instr.length, clock_count}, 11'h10c)
        do_reset();
        pm.mem[0] = 8'h80;
        pm.mem[1] = 8'h80;
        wait_op(8'h80, 300);
        `CHK(operand.target, 16'hff82)
        // page jump whose next instruction starts a new 2k page
        do_reset();
        mode = 1'b0;
        lag = 2'h0;
        pm.mem[16'h07fe] = 8'he1;
        pm.mem[16'h07ff] = 8'h34;
        wait_op(8'he1, 40000);
        `CHK(operand.target, 16'h0f34)
        end_of_test();
    end
endmodule // cpu_operation_code_byte_decode_timing_tb_top
